// >>> sig_pkg.sv
/*
  constants shared by the initiator-side bus controller and its fifo.
  assumes a 100 mhz system clock and a 16-bit wide parallel bus.
*/
package sig_pkg;
  localparam int          DATA_W      = 16;           // wide bus data lanes
  localparam int          ID_W        = 4;            // ids 0 to 15
  localparam int          FIFO_W      = 16;           // fifo word width
  localparam int          FIFO_D      = 4;            // fifo depth in words
  localparam int          CLK_NS      = 10;           // system clock period
  localparam int          RST_HOLD_NS = 25000;        // bus reset pulse length
  localparam int          RST_HOLD_CY = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SEL_TMO_NS  = 250000;       // selection timeout
  localparam int          SEL_TMO_CY  = SEL_TMO_NS / CLK_NS;
  localparam int          CNT_W       = 16;           // timer width
  localparam logic [15:0] DATA_RST    = 16'h0000;     // idle data value
endpackage

// >>> sig_fifo.sv
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module sig_fifo #(
  parameter int WIDTH = 16,  // word width
  parameter int DEPTH = 4    // number of words
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst,       // sync reset, high
  input  wire logic [WIDTH-1:0] in_data,   // word in
  input  wire logic             in_valid,  // word in valid
  output logic                  in_ready,  // room available
  output logic      [WIDTH-1:0] out_data,  // word out
  output logic                  out_valid, // word out valid
  input  wire logic             out_ready  // drain accepts word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];       // storage
  logic [AW-1:0]    wr_reg;                // write index
  logic [AW-1:0]    rd_reg;                // read index
  logic [AW:0]      cnt_reg;               // fill count
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;
  logic [AW:0]      cnt_next;              // fill count after this edge
  logic             full_reg;              // registered full flag

  // full flag kept in a flop so room is a clean register output
  assign cnt_next  = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  assign in_ready  = !full_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  // storage write
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
      mem_reg[wr_reg] <= in_data;
  end

  // pointers and count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
    end
    else
    begin
      if (do_wr)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (do_rd)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg  <= cnt_next;
      full_reg <= (cnt_next == (AW+1)'(DEPTH));
    end
  end
endmodule

// >>> sig_init.sv
/*
  initiator controller for a wired-or parallel peripheral bus: reset,
  selection, phase tracking, req/ack byte handshake, attention, parity.
  assumes pins are synchronous to sys_clk and the target obeys the
  handshake; bus lines are active high here, transceivers invert.
*/
// How it works
// - bus reset abandons everything, returns idle
// - busy is wired-or, any driver occupies bus
// - target c/d marks control versus data
// - target i/o sets transfer direction
// - i/o separates selection from reselection
// - target req announces byte, drops after ack
// - msg marks message phase, i/o picks direction
// - each lane odd parity over eight bits
// - bit 7 highest priority, msb
// - parity optional, never checked in arbitration
`timescale 1ns/10ps
module sig_init (
  input  wire logic                        sys_clk,     // system clock
  input  wire logic                        rst,         // sync reset, high
  input  wire logic                        cmd_reset,   // pulse: issue bus reset
  input  wire logic                        cmd_select,  // pulse: start selection
  input  wire logic [sig_pkg::ID_W-1:0]    own_id,      // our id
  input  wire logic [sig_pkg::ID_W-1:0]    tgt_id,      // target id
  input  wire logic                        wide_en,     // 16-bit transfers
  input  wire logic                        par_en,      // parity enable
  input  wire logic                        atn_req,     // want attention
  input  wire logic [sig_pkg::FIFO_W-1:0]  tx_data,     // outgoing word
  input  wire logic                        tx_valid,    // outgoing valid
  output logic                             tx_ready,    // fifo has room
  output logic [sig_pkg::DATA_W-1:0]       rx_data,     // incoming word
  output logic                             rx_valid,    // pulse: word received
  output logic [2:0]                       phase,       // msg,c/d,i/o latched
  output logic                             connected,   // target connected
  output logic                             sel_timeout, // pulse: no answer
  output logic                             par_error,   // pulse: parity bad
  output logic                             reselected,  // pulse: reselect seen
  input  wire logic [sig_pkg::DATA_W-1:0]  db_i,        // data lines in
  output logic [sig_pkg::DATA_W-1:0]       db_o,        // data lines out
  output logic                             db_oe,       // data drive enable
  input  wire logic [1:0]                  dbp_i,       // parity lines in
  output logic [1:0]                       dbp_o,       // parity lines out
  output logic                             dbp_oe,      // parity drive enable
  input  wire logic                        bsy_i,       // busy in
  input  wire logic                        sel_i,       // select in
  output logic                             sel_o,       // select out
  output logic                             sel_oe,      // select enable
  input  wire logic                        rst_i,       // bus reset in
  output logic                             rst_o,       // bus reset out
  output logic                             rst_oe,      // bus reset enable
  input  wire logic                        req_i,       // request from target
  input  wire logic                        cd_i,        // control/data
  input  wire logic                        io_i,        // input/output
  input  wire logic                        msg_i,       // message
  output logic                             ack_o,       // acknowledge
  output logic                             atn_o        // attention
);
  import sig_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RESET, S_SEL, S_CONN, S_ACK} sig_st_t;

  // odd parity bit for one byte
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction

  // one-hot id bit on the wide lanes
  function automatic logic [DATA_W-1:0] id_bit(input logic [ID_W-1:0] id);
    id_bit = DATA_W'(1) << id;
  endfunction

  sig_st_t             st_reg, st_next;     // controller state
  logic [CNT_W-1:0]    cnt_reg;             // reset and timeout timer
  logic [DATA_W-1:0]   db_reg;              // driven data
  logic                db_oe_reg;           // data drive
  logic [1:0]          dbp_reg;             // driven parity
  logic                sel_reg;             // select drive
  logic                rst_reg;             // reset drive
  logic                ack_reg;             // ack drive
  logic                atn_reg;             // attention drive
  logic [DATA_W-1:0]   rxd_reg;             // captured word
  logic                rxv_reg;             // capture pulse
  logic [2:0]          ph_reg;              // latched phase
  logic                tmo_reg;             // timeout pulse
  logic                perr_reg;            // parity error pulse
  logic                resel_reg;           // reselection pulse
  logic                conn_reg;            // target connected flag
  logic [FIFO_W-1:0]   f_data;              // fifo head
  logic                f_valid;             // fifo head valid

  // decode of bus state
  wire bus_reset  = rst_i;
  wire bus_busy   = bsy_i;
  wire dir_in     = io_i;
  wire is_msg     = msg_i;
  wire is_ctrl    = cd_i;
  // selection with i/o asserted is a reselection by a target
  wire resel_seen = sel_i && io_i && !sel_reg && !bus_busy;
  wire [DATA_W-1:0] sel_bits = id_bit(own_id) | id_bit(tgt_id);
  wire p_lo_bad   = dbp_i[0] != odd_par(db_i[7:0]);
  wire p_hi_bad   = wide_en && (dbp_i[1] != odd_par(db_i[15:8]));
  // only checked during information transfer, never arbitration
  wire par_bad    = par_en && dir_in && (p_lo_bad || p_hi_bad);
  wire take_out   = (st_reg == S_CONN) && req_i && !dir_in && f_valid;
  wire take_in    = (st_reg == S_CONN) && req_i && dir_in;
  wire f_pop      = take_out;
  wire [DATA_W-1:0] out_word = wide_en ? f_data : {8'h00, f_data[7:0]};
  wire [1:0]      out_par  = {odd_par(out_word[15:8]), odd_par(out_word[7:0])};

  sig_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // next state
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      S_IDLE:
        if (cmd_reset)
          st_next = S_RESET;
        else if (cmd_select && !bus_busy && !sel_i)
          st_next = S_SEL;
      S_RESET:
        if (cnt_reg == CNT_W'(RST_HOLD_CY - 1))
          st_next = S_IDLE;
      S_SEL:
        if (bus_busy)
          st_next = S_CONN;
        else if (cnt_reg == CNT_W'(SEL_TMO_CY - 1))
          st_next = S_IDLE;
      S_CONN:
        if (!bus_busy)
          st_next = S_IDLE;
        else if (take_out || take_in)
          st_next = S_ACK;
      S_ACK:
        if (!req_i)
          st_next = bus_busy ? S_CONN : S_IDLE;
    endcase
    if (bus_reset && st_reg != S_RESET)
      st_next = S_IDLE;
  end

  // state and timer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg  <= S_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      st_reg  <= st_next;
      cnt_reg <= (st_next != st_reg) ? '0 : cnt_reg + 1'b1;
    end
  end

  // bus drivers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      db_reg    <= DATA_RST;
      db_oe_reg <= 1'b0;
      dbp_reg   <= 2'b00;
      sel_reg   <= 1'b0;
      rst_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      atn_reg   <= 1'b0;
    end
    else
    begin
      rst_reg <= (st_next == S_RESET);
      sel_reg <= (st_next == S_SEL);
      ack_reg <= (st_next == S_ACK);
      atn_reg <= atn_req && (st_next == S_SEL || st_next == S_CONN
                 || st_next == S_ACK);
      if (st_next == S_SEL)
      begin
        db_reg    <= sel_bits;
        db_oe_reg <= 1'b1;
        dbp_reg   <= {odd_par(sel_bits[15:8]), odd_par(sel_bits[7:0])};
      end
      else if (take_out)
      begin
        db_reg    <= out_word;
        db_oe_reg <= 1'b1;
        dbp_reg   <= out_par;
      end
      else if (st_next != S_ACK)
        db_oe_reg <= 1'b0;
    end
  end

  // received data and status pulses
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rxd_reg   <= DATA_RST;
      rxv_reg   <= 1'b0;
      ph_reg    <= 3'b000;
      tmo_reg   <= 1'b0;
      perr_reg  <= 1'b0;
      resel_reg <= 1'b0;
      conn_reg  <= 1'b0;
    end
    else
    begin
      rxv_reg   <= take_in;
      perr_reg  <= take_in && par_bad;
      tmo_reg   <= (st_reg == S_SEL) && (st_next == S_IDLE) && !bus_reset;
      resel_reg <= (st_reg == S_IDLE) && resel_seen;
      // connected mirrors the state so the pin comes from a flop
      conn_reg  <= (st_next == S_CONN) || (st_next == S_ACK);
      if (take_in)
        rxd_reg <= wide_en ? db_i : {8'h00, db_i[7:0]};
      if (st_reg == S_CONN)
        ph_reg <= {is_msg, is_ctrl, dir_in};
    end
  end

  // outputs straight from flops
  assign rx_data     = rxd_reg;
  assign rx_valid    = rxv_reg;
  assign phase       = ph_reg;
  assign connected   = conn_reg;
  assign sel_timeout = tmo_reg;
  assign par_error   = perr_reg;
  assign reselected  = resel_reg;
  assign db_o        = db_reg;
  assign db_oe       = db_oe_reg;
  assign dbp_o       = dbp_reg;
  assign dbp_oe      = db_oe_reg;
  assign sel_o       = sel_reg;
  assign sel_oe      = sel_reg;
  assign rst_o       = rst_reg;
  assign rst_oe      = rst_reg;
  assign ack_o       = ack_reg;
  assign atn_o       = atn_reg;
endmodule

// >>> sig_init_properties.sv
/*
  timing checks on the initiator controller ports.
  assumes one clock domain and bind onto every sig_init instance.
*/
`timescale 1ns/10ps
module sig_init_chk (
  input wire logic        sys_clk,   // system clock
  input wire logic        rst,       // sync reset
  input wire logic [3:0]  own_id,    // our id
  input wire logic [3:0]  tgt_id,    // target id
  input wire logic        atn_req,   // attention wanted
  input wire logic        par_en,    // parity enable
  input wire logic        rx_valid,  // word received
  input wire logic        connected, // target linked
  input wire logic        par_error, // parity flag
  input wire logic [15:0] db_i,      // data lines in
  input wire logic [15:0] db_o,      // data lines out
  input wire logic        db_oe,     // data enable
  input wire logic [1:0]  dbp_i,     // parity in
  input wire logic [1:0]  dbp_o,     // parity out
  input wire logic        bsy_i,     // busy
  input wire logic        sel_o,     // select
  input wire logic        rst_i,     // bus reset in
  input wire logic        rst_o,     // bus reset out
  input wire logic        req_i,     // request
  input wire logic        io_i,      // direction
  input wire logic        ack_o,     // acknowledge
  input wire logic        atn_o      // attention
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property (rst_i && !rst_o |=> !connected)
    else $error("link kept through bus reset");
  a_reset_hold: assert property ($rose(rst_o) |=> rst_o [*8])
    else $error("bus reset pulse cut short");
  a_select_ids: assert property ($rose(sel_o) |->
    db_oe && db_o[own_id] && db_o[tgt_id])
    else $error("id bits missing at select");
  a_select_release: assert property (sel_o && bsy_i |=> !sel_o)
    else $error("select held after busy");
  a_ack_answer: assert property (connected && io_i && $rose(req_i) |=>
    ack_o && rx_valid)
    else $error("input byte not acknowledged");
  a_ack_hold: assert property (ack_o && req_i |=> ack_o)
    else $error("ack dropped while req high");
  a_ack_drop: assert property (ack_o && !req_i |=> !ack_o)
    else $error("ack kept after req fell");
  a_attn_follow: assert property (connected && atn_req |-> ##[0:1] atn_o)
    else $error("attention not driven");
  a_out_parity: assert property (ack_o && db_oe && par_en |->
    dbp_o == {~^db_o[15:8], ~^db_o[7:0]})
    else $error("outgoing parity not odd");
  a_parity_flag: assert property (connected && io_i && par_en && $rose(req_i)
    && dbp_i[0] == ^db_i[7:0] |=> par_error)
    else $error("bad parity not flagged");
endmodule
bind sig_init sig_init_chk u_chk (.sys_clk, .rst, .own_id, .tgt_id, .atn_req, .par_en,
  .rx_valid, .connected, .par_error, .db_i, .db_o, .db_oe, .dbp_i, .dbp_o, .bsy_i,
  .sel_o, .rst_i, .rst_o, .req_i, .io_i, .ack_o, .atn_o);

// >>> sig_tgt_model.sv
/*
  behavioural target on the far side of the bus.
  assumes the bench resolves the wired lines and calls xfer.
*/
`timescale 1ns/10ps
module sig_tgt_model #(
  parameter int MY_ID = 5  // our bus id
) (
  input  wire logic        sys_clk,  // system clock
  input  wire logic        rst_i,    // bus reset level
  input  wire logic        sel_i,    // select level
  input  wire logic [15:0] db_i,     // resolved data
  input  wire logic        ack_i,    // acknowledge
  output logic             bsy,      // busy drive
  output logic             req,      // request
  output logic [2:0]       ph,       // msg, c/d, i/o
  output logic [15:0]      db,       // data drive
  output logic [1:0]       dbp,      // parity drive
  output logic             got_stb,  // out word taken
  output logic [15:0]      got_data  // out word value
);
  initial {bsy, req, ph, db, dbp, got_stb, got_data} = {5'h00, 16'h5a5a, 2'h0, 1'b0, 16'h0000};
  // answer our selection, drop busy and req on bus reset
  always @(negedge sys_clk)
    if (rst_i)
      {bsy, req} = 2'b00;
    else if (sel_i && db_i[MY_ID] && !ph[0])
      bsy = 1'b1;
  // one req/ack handshake, lag stalls the release, bad spoils a byte's parity
  task automatic xfer(input logic [2:0] p, input logic [15:0] d, input logic [1:0] bad,
                      input int lag);
    int n;
    @(negedge sys_clk);
    ph = p;
    if (p[0])
      {db, dbp} = {d, ~^d[15:8] ^ bad[1], ~^d[7:0] ^ bad[0]};
    req = 1'b1;
    for (n = 0; n < 64 && ack_i !== 1'b1; n++) @(negedge sys_clk);
    got_data = db_i;
    got_stb  = !p[0];
    @(negedge sys_clk);
    got_stb = 1'b0;
    repeat (lag) @(negedge sys_clk);
    req = 1'b0;
    db  = ~db;  // released lines show the inverse of the last value
    for (n = 0; n < 64 && ack_i !== 1'b0; n++) @(negedge sys_clk);
  endtask
endmodule

// >>> sig_init_test.sv
/*
  self-checking bench: initiator controller against one target model.
  assumes the package, fifo, controller, checker and model compiled first.
*/
`timescale 1ns/10ps
module sig_init_test;
  import sig_pkg::*;
  logic sys_clk = 0, rst = 1, cmd_reset = 0, cmd_select = 0, wide_en = 1, par_en = 1;
  logic atn_req = 0, tx_valid = 0, ext_rst = 0, tx_ready, rx_valid, connected, sel_timeout;
  logic par_error, reselected, db_oe, dbp_oe, bsy_i, sel_i, sel_o, sel_oe, rst_i, rst_o;
  logic rst_oe, req_i, ack_o, atn_o, got_stb, ext_sel = 0, exp_pe[$];
  wire  cd_i, io_i, msg_i;
  logic [3:0]  own_id = 4'hf, tgt_id = 4'h5, mon;
  logic [15:0] tx_data = 16'h0000, rx_data, db_i, db_o, m_db, got_data, exp_rx[$], exp_tx[$];
  logic [1:0]  dbp_i, dbp_o, m_dbp;
  logic [2:0]  phase;
  logic [31:0] lfsr = 32'h6855;
  int          err_count = 0, samples_checked = 0, n;
  always #5 sys_clk = ~sys_clk;
  assign sel_i = (sel_o & sel_oe) | ext_sel;
  assign rst_i = (rst_o & rst_oe) | ext_rst;
  assign db_i  = db_oe ? db_o : m_db;
  assign dbp_i = dbp_oe ? dbp_o : m_dbp;
  assign mon   = {connected, sel_o, rst_o, 1'b0};
  sig_init DUT (.sys_clk, .rst, .cmd_reset, .cmd_select, .own_id, .tgt_id, .wide_en, .par_en,
    .atn_req, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .phase, .connected,
    .sel_timeout, .par_error, .reselected, .db_i, .db_o, .db_oe, .dbp_i, .dbp_o, .dbp_oe,
    .bsy_i, .sel_i, .sel_o, .sel_oe, .rst_i, .rst_o, .rst_oe, .req_i, .cd_i, .io_i, .msg_i,
    .ack_o, .atn_o);
  sig_tgt_model #(.MY_ID(5)) TGT (.sys_clk, .rst_i, .sel_i, .db_i, .ack_i(ack_o), .bsy(bsy_i),
    .req(req_i), .ph({msg_i, cd_i, io_i}), .db(m_db), .dbp(m_dbp), .got_stb, .got_data);
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic await(input int b, input logic v);
    for (n = 0; n < 3000 && mon[b] !== v; n++) @(negedge sys_clk);
    if (n == 3000)
    begin
      err_count++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  // result watchers take the oldest note
  always @(negedge sys_clk)
    if (rx_valid === 1'b1)
    begin
      chk(rx_data, exp_rx.pop_front());
      chk(16'(par_error), 16'(exp_pe.pop_front()));
    end
  always @(posedge sys_clk)
    if (got_stb === 1'b1)
      chk(got_data, exp_tx.pop_front());
  initial
  begin
    repeat (10) @(negedge sys_clk);
    rst = 0;
    chk(16'({tx_ready, sel_o, rst_o, ack_o, connected, db_oe}), 16'h0020);
    cmd_reset = 1;
    @(negedge sys_clk) cmd_reset = 0;
    await(1, 1);
    for (n = 0; n < 3000 && rst_o; n++) @(negedge sys_clk);
    chk(16'(n), 16'(RST_HOLD_CY));
    repeat (2) @(negedge sys_clk);
    cmd_select = 1;
    @(negedge sys_clk) cmd_select = 0;
    await(2, 1);
    chk(db_o, 16'h8020);
    await(3, 1);
    chk(16'(sel_o), 16'h0000);
    repeat (6)
    begin
      tx_data  = rnd();
      tx_valid = tx_ready;
      if (tx_ready)
        exp_tx.push_back(tx_data);
      @(negedge sys_clk);
    end
    tx_valid = 0;
    chk(16'(tx_ready), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      TGT.xfer({i[1], i[0] | i[1], 1'b0}, 16'h0000, 2'b00, i);
      chk(16'(phase), 16'({i[1], i[0] | i[1], 1'b0}));
    end
    chk(16'(tx_ready), 16'h0001);
    // bytes 3 and 4 spoil low and high parity, byte 5 spoils it with checking off
    for (int i = 0; i < 6; i++)
    begin
      tx_data = rnd();
      wide_en = i != 2;
      par_en  = i != 5;
      exp_rx.push_back(wide_en ? tx_data : {8'h00, tx_data[7:0]});
      exp_pe.push_back(i == 3 || i == 4);
      TGT.xfer({i[1], i[0] | i[1], 1'b1}, tx_data, {i == 4, i == 3 || i == 5},
               0);
    end
    wide_en = 1;
    par_en  = 1;
    atn_req = 1;
    repeat (2) @(negedge sys_clk);
    chk(16'(atn_o), 16'h0001);
    atn_req = 0;
    ext_rst = 1;
    repeat (3) @(negedge sys_clk);
    ext_rst = 0;
    chk(16'(connected), 16'h0000);
    // a target selecting with i/o high is a reselection
    ext_sel = 1;
    @(negedge sys_clk) ext_sel = 0;
    chk(16'(reselected), 16'h0001);
    // nobody answers id 3, so selection must time out
    tgt_id     = 4'h3;
    cmd_select = 1;
    @(negedge sys_clk) cmd_select = 0;
    for (n = 0; n < 26000 && sel_o; n++) @(negedge sys_clk);
    chk(16'(n), 16'(SEL_TMO_CY));
    chk(16'(sel_timeout), 16'h0001);
    repeat (4) @(negedge sys_clk);
    chk(16'(exp_rx.size() + exp_tx.size() + exp_pe.size()), 16'h0000);
    give_verdict();
  end
endmodule
